// file: fmsp_defines.svh
// Timing counts, encodings and reset levels of the four mode serial port.
`ifndef FMSP_DEFINES_SVH
`define FMSP_DEFINES_SVH

// ----------------------------------------------------------------------
// Mode select encodings {mode_select_high, mode_select_low}
// ----------------------------------------------------------------------
`define FMSP_MODE_SYNC      2'h0
`define FMSP_MODE_ASYNC10   2'h1
`define FMSP_MODE_ASYNC11F  2'h2
`define FMSP_MODE_ASYNC11T  2'h3

// ----------------------------------------------------------------------
// Synchronous shift phases, in system clocks, counted from data change
// ----------------------------------------------------------------------
`define FMSP_M0_FAST_LAST   4'h3
`define FMSP_M0_FAST_FALL   4'h1
`define FMSP_M0_FAST_RISE   4'h3
`define FMSP_M0_SLOW_LAST   4'hB
`define FMSP_M0_SLOW_FALL   4'h3
`define FMSP_M0_SLOW_RISE   4'h9
`define FMSP_SYNC_BITS      4'h8

// ----------------------------------------------------------------------
// Asynchronous framing: sixteen sample ticks per bit
// ----------------------------------------------------------------------
`define FMSP_TICK_LAST      4'hF
`define FMSP_TICK_MID       4'h7
`define FMSP_ASYNC10_BITS   4'h9
`define FMSP_ASYNC11_BITS   4'hA
`define FMSP_M2_DIV_NORM    3'h4
`define FMSP_M2_DIV_DBL     3'h2

// ----------------------------------------------------------------------
// Reset levels
// ----------------------------------------------------------------------
`define FMSP_LINE_IDLE      1'b1
`define FMSP_RBUF_RST       8'h00

`endif

// file: fmsp_peer.sv
// Far-side model: shift register peer and asynchronous serial peer.
`timescale 1ns/100ps
module fmsp_peer (
    input  wire logic i_sys_clk,
    input  wire logic i_clk_pin,
    input  wire logic i_dat_pin,
    input  wire logic i_oe_n,
    output logic      o_line
);
    logic [7:0] sync_rx;
    logic [7:0] sync_tx;
    logic       clk_q;
    logic       armed;
    initial begin
        o_line = 1'b1;
        armed = 1'b0;
        clk_q = 1'b1;
    end
    // Each bit is taken at the shift clock rise and the next one offered
    // just after it; spent bits become ones, as a pulled-up line would.
    always @(posedge i_sys_clk) begin
        clk_q <= i_clk_pin;
        if (!clk_q && i_clk_pin && !i_oe_n) begin
            sync_rx <= {i_dat_pin, sync_rx[7:1]};
        end
        if (!clk_q && i_clk_pin && i_oe_n && armed) begin
            sync_tx <= {1'b1, sync_tx[7:1]};
            o_line <= sync_tx[1];
        end
    end
    task automatic arm_sync(input logic [7:0] b);
        sync_tx <= b;
        o_line <= b[0];
        armed <= 1'b1;
    endtask
    task automatic send_frame(input logic [10:0] f, input int n,
                              input int cpb);
        for (int i = 0; i < n; i++) begin
            o_line <= f[i];
            repeat (cpb) @(posedge i_sys_clk);
        end
        o_line <= 1'b1;
    endtask
    task automatic get_frame(input int n, input int cpb,
                             output logic [10:0] f);
        int t;
        f = 11'h7FF;
        t = 0;
        while (i_clk_pin === 1'b1 && t < 8000) begin
            @(posedge i_sys_clk);
            t++;
        end
        repeat (cpb / 2) @(posedge i_sys_clk);
        for (int i = 0; i < n; i++) begin
            f[i] = i_clk_pin;
            repeat (cpb) @(posedge i_sys_clk);
        end
    endtask
endmodule

// file: fmsp_pkg.sv
// Types shared by the four mode serial port modules.
package fmsp_pkg;

    typedef enum logic [1:0] {
        FMSP_TX_IDLE,
        FMSP_TX_SYNC,
        FMSP_TX_ASYNC
    } fmsp_tx_state_t;

    typedef enum logic [1:0] {
        FMSP_RX_IDLE,
        FMSP_RX_SYNC,
        FMSP_RX_START,
        FMSP_RX_DATA
    } fmsp_rx_state_t;

    typedef struct packed {
        fmsp_tx_state_t tx_st;
        logic [9:0]     tx_shift;
        logic [3:0]     tx_bits;
        logic [3:0]     tx_tick;
        fmsp_rx_state_t rx_st;
        logic [8:0]     rx_shift;
        logic [3:0]     rx_bits;
        logic [3:0]     rx_tick;
        logic [3:0]     m0_ph;
        logic           sync0;
        logic           sync1;
        logic           data_prev;
        logic [7:0]     rbuf;
        logic           rb8;
        logic           ri;
        logic           ti;
        logic           data_out;
        logic           data_oe_n;
        logic           clk_out;
    } fmsp_state_t;

    typedef struct packed {
        logic [2:0] div_cnt;
        logic       ovf_half;
        logic       tick;
    } fmsp_rate_state_t;

endpackage

// file: fmsp_rate_gen.sv
// Sample tick generator: sixteen ticks per asynchronous bit.
`timescale 1ns/100ps
`include "fmsp_defines.svh"

module fmsp_rate_gen #(
    parameter int DIV_W = 3
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_mode,
    input  wire logic       i_double_rate,
    input  wire logic       i_timer_overflow,
    output logic            o_sample_tick
);
    import fmsp_pkg::*;

    fmsp_rate_state_t s;
    fmsp_rate_state_t next_s;

    if (DIV_W != 3) begin : g_check
        $error("fmsp_rate_gen: DIV_W must be 3 to hold the divider");
    end

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // The fixed-rate mode divides the system clock by 4 or 2 per tick,
    // giving 64 or 32 clocks per bit. The timer modes halve the timer
    // overflow rate unless the double rate bit is set.
    always_comb begin
        logic [2:0] div;
        div = i_double_rate ? `FMSP_M2_DIV_DBL : `FMSP_M2_DIV_NORM;
        next_s = s;
        next_s.tick = 1'b0;
        if (i_mode == `FMSP_MODE_ASYNC11F) begin
            if (s.div_cnt >= div - 3'h1) begin
                next_s.div_cnt = 3'h0;
                next_s.tick = 1'b1;
            end else begin
                next_s.div_cnt = s.div_cnt + 3'h1;
            end
        end else if (i_timer_overflow) begin
            next_s.div_cnt = 3'h0;
            next_s.ovf_half = ~s.ovf_half;
            next_s.tick = i_double_rate | s.ovf_half;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_sample_tick = s.tick;
endmodule

// file: fmsp_serial_port.sv
// Four mode serial port: synchronous shift and asynchronous UART.
`timescale 1ns/100ps
`include "fmsp_defines.svh"

module fmsp_serial_port (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_mode_select_high,
    input  wire logic       i_mode_select_low,
    input  wire logic       i_shift_rate_or_multiproc_bit,
    input  wire logic       i_receive_enable,
    input  wire logic       i_double_rate,
    input  wire logic       i_timer_overflow,
    input  wire logic       i_transmit_ninth_bit,
    input  wire logic       i_serial_data_buffer_write,
    input  wire logic [7:0] i_serial_data_buffer_wdata,
    input  wire logic       i_clear_receive_done,
    input  wire logic       i_clear_transmit_done,
    input  wire logic       i_data_pin,
    output logic            o_data_pin,
    output logic            o_data_pin_oe_n,
    output logic            o_clock_pin,
    output logic [7:0]      o_serial_data_buffer,
    output logic            o_ninth_receive_bit,
    output logic            o_receive_done_flag,
    output logic            o_transmit_done_flag,
    output logic            o_transmit_busy,
    output logic            o_receive_busy
);
    import fmsp_pkg::*;

    localparam fmsp_state_t STATE_RST = '{
        tx_st:     FMSP_TX_IDLE,
        tx_shift:  10'h3FF,
        tx_bits:   4'h0,
        tx_tick:   4'h0,
        rx_st:     FMSP_RX_IDLE,
        rx_shift:  9'h000,
        rx_bits:   4'h0,
        rx_tick:   4'h0,
        m0_ph:     4'h0,
        sync0:     `FMSP_LINE_IDLE,
        sync1:     `FMSP_LINE_IDLE,
        data_prev: `FMSP_LINE_IDLE,
        rbuf:      `FMSP_RBUF_RST,
        rb8:       1'b0,
        ri:        1'b0,
        ti:        1'b0,
        data_out:  `FMSP_LINE_IDLE,
        data_oe_n: 1'b1,
        clk_out:   `FMSP_LINE_IDLE
    };

    fmsp_state_t s;
    fmsp_state_t next_s;
    logic [1:0]  mode;
    logic        sample_tick;
    logic        busy_q;
    logic        rbusy_q;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Phase limits of one synchronous bit: 0 last, 1 fall, 2 rise.
    function automatic logic [3:0] m0_limit(input logic fast,
                                            input logic [1:0] sel);
        logic [3:0] v;
        case (sel)
            2'h0:    v = fast ? `FMSP_M0_FAST_LAST : `FMSP_M0_SLOW_LAST;
            2'h1:    v = fast ? `FMSP_M0_FAST_FALL : `FMSP_M0_SLOW_FALL;
            default: v = fast ? `FMSP_M0_FAST_RISE : `FMSP_M0_SLOW_RISE;
        endcase
        return v;
    endfunction

    // Bits following the start bit, stop bit included.
    function automatic logic [3:0] frame_bits(input logic [1:0] m);
        return (m == `FMSP_MODE_ASYNC10) ? `FMSP_ASYNC10_BITS
                                         : `FMSP_ASYNC11_BITS;
    endfunction

    assign mode = {i_mode_select_high, i_mode_select_low};

    fmsp_rate_gen #(
        .DIV_W            (3)
    ) u_rate (
        .i_sys_clk        (i_sys_clk),
        .i_rst            (i_rst),
        .i_mode           (mode),
        .i_double_rate    (i_double_rate),
        .i_timer_overflow (i_timer_overflow),
        .o_sample_tick    (sample_tick)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic       sync_mode;
        logic       fast;
        logic       set_ti;
        logic       set_ri;
        logic       m0_active;
        logic [3:0] nph;
        logic [3:0] nbits;
        logic       accept;
        sync_mode = (mode == `FMSP_MODE_SYNC);
        fast = i_shift_rate_or_multiproc_bit;
        set_ti = 1'b0;
        set_ri = 1'b0;
        accept = 1'b0;
        nbits = frame_bits(mode);
        m0_active = (s.tx_st == FMSP_TX_SYNC) || (s.rx_st == FMSP_RX_SYNC);
        nph = (s.m0_ph == m0_limit(fast, 2'h0)) ? 4'h0 : s.m0_ph + 4'h1;
        next_s = s;

        // The first stage only feeds the second; edges use later stages.
        next_s.sync0 = i_data_pin;
        next_s.sync1 = s.sync0;
        next_s.data_prev = s.sync1;

        // --------------------------------------------------------------
        // Synchronous shift engine, shared by both directions
        // --------------------------------------------------------------
        if (m0_active) begin
            next_s.m0_ph = nph;
            if (nph == m0_limit(fast, 2'h1)) begin
                next_s.clk_out = 1'b0;
            end
            if (nph == m0_limit(fast, 2'h2)) begin
                next_s.clk_out = 1'b1;
                next_s.tx_bits = s.tx_bits + 4'h1;
                if (s.rx_st == FMSP_RX_SYNC) begin
                    next_s.rx_shift = {1'b0, s.sync1, s.rx_shift[7:1]};
                end
            end
            if (nph == 4'h0) begin
                if (s.tx_bits == `FMSP_SYNC_BITS) begin
                    next_s.data_oe_n = 1'b1;
                    next_s.data_out = `FMSP_LINE_IDLE;
                    if (s.tx_st == FMSP_TX_SYNC) begin
                        next_s.tx_st = FMSP_TX_IDLE;
                        set_ti = 1'b1;
                    end else begin
                        next_s.rx_st = FMSP_RX_IDLE;
                        next_s.rbuf = s.rx_shift[7:0];
                        set_ri = 1'b1;
                    end
                end else if (s.tx_st == FMSP_TX_SYNC) begin
                    next_s.tx_shift = {1'b1, s.tx_shift[9:1]};
                    next_s.data_out = s.tx_shift[1];
                end
            end
        end

        // --------------------------------------------------------------
        // Transmit start and asynchronous transmitter
        // --------------------------------------------------------------
        if (s.tx_st == FMSP_TX_ASYNC && sample_tick) begin
            next_s.tx_tick = s.tx_tick + 4'h1;
            if (s.tx_tick == `FMSP_TICK_LAST) begin
                if (s.tx_bits == nbits) begin
                    next_s.tx_st = FMSP_TX_IDLE;
                    next_s.clk_out = `FMSP_LINE_IDLE;
                    set_ti = 1'b1;
                end else begin
                    next_s.clk_out = s.tx_shift[0];
                    next_s.tx_shift = {1'b1, s.tx_shift[9:1]};
                    next_s.tx_bits = s.tx_bits + 4'h1;
                end
            end
        end
        // A write while a transmit frame or a shift receive is in flight is dropped; the transmit
        // flag tells software when the buffer may be written again.
        if (i_serial_data_buffer_write && s.tx_st == FMSP_TX_IDLE &&
            s.rx_st != FMSP_RX_SYNC) begin
            next_s.tx_bits = 4'h0;
            next_s.tx_tick = 4'h0;
            if (sync_mode) begin
                next_s.tx_st = FMSP_TX_SYNC;
                next_s.tx_shift = {2'h3, i_serial_data_buffer_wdata};
                next_s.data_out = i_serial_data_buffer_wdata[0];
                next_s.data_oe_n = 1'b0;
                next_s.m0_ph = 4'h0;
            end else begin
                next_s.tx_st = FMSP_TX_ASYNC;
                next_s.clk_out = 1'b0;
                next_s.tx_shift = (mode == `FMSP_MODE_ASYNC10) ?
                    {2'h3, i_serial_data_buffer_wdata} :
                    {1'b1, i_transmit_ninth_bit,
                     i_serial_data_buffer_wdata};
            end
        end

        // --------------------------------------------------------------
        // Receivers
        // --------------------------------------------------------------
        case (s.rx_st)
            FMSP_RX_IDLE: begin
                if (sync_mode) begin
                    if (!s.ri && i_receive_enable && !m0_active &&
                        !i_serial_data_buffer_write) begin
                        next_s.rx_st = FMSP_RX_SYNC;
                        next_s.tx_bits = 4'h0;
                        next_s.m0_ph = 4'h0;
                        next_s.data_oe_n = 1'b1;
                    end
                end else if (i_receive_enable && s.data_prev &&
                             !s.sync1) begin
                    next_s.rx_st = FMSP_RX_START;
                    next_s.rx_tick = 4'h0;
                end
            end
            FMSP_RX_START: begin
                if (sample_tick) begin
                    next_s.rx_tick = s.rx_tick + 4'h1;
                    if (s.rx_tick == `FMSP_TICK_MID) begin
                        // A glitch shorter than half a bit is no start.
                        next_s.rx_st = s.sync1 ? FMSP_RX_IDLE : FMSP_RX_DATA;
                        next_s.rx_tick = 4'h0;
                        next_s.rx_bits = 4'h0;
                    end
                end
            end
            FMSP_RX_DATA: begin
                if (sample_tick) begin
                    next_s.rx_tick = s.rx_tick + 4'h1;
                    if (s.rx_tick == `FMSP_TICK_LAST) begin
                        next_s.rx_bits = s.rx_bits + 4'h1;
                        if (s.rx_bits == nbits - 4'h1) begin
                            next_s.rx_st = FMSP_RX_IDLE;
                            if (mode == `FMSP_MODE_ASYNC10) begin
                                accept = !s.ri &&
                                    (!i_shift_rate_or_multiproc_bit ||
                                     s.sync1);
                                if (accept) begin
                                    next_s.rbuf = s.rx_shift[8:1];
                                    next_s.rb8 = s.sync1;
                                end
                            end else begin
                                accept = !s.ri &&
                                    (!i_shift_rate_or_multiproc_bit ||
                                     s.rx_shift[8]);
                                if (accept) begin
                                    next_s.rbuf = s.rx_shift[7:0];
                                    next_s.rb8 = s.rx_shift[8];
                                end
                            end
                            set_ri = accept;
                        end else begin
                            next_s.rx_shift = {s.sync1, s.rx_shift[8:1]};
                        end
                    end
                end
            end
            default: begin
            end
        endcase

        // Hardware setting a flag wins over a clear in the same cycle.
        next_s.ti = set_ti | (s.ti & ~i_clear_transmit_done);
        next_s.ri = set_ri | (s.ri & ~i_clear_receive_done);
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= STATE_RST;
            busy_q <= 1'b0;
            rbusy_q <= 1'b0;
        end else begin
            s <= next_s;
            busy_q <= (next_s.tx_st != FMSP_TX_IDLE);
            rbusy_q <= (next_s.rx_st != FMSP_RX_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from state flip-flops
    // ------------------------------------------------------------------
    assign o_data_pin           = s.data_out;
    assign o_data_pin_oe_n      = s.data_oe_n;
    assign o_clock_pin          = s.clk_out;
    assign o_serial_data_buffer = s.rbuf;
    assign o_ninth_receive_bit  = s.rb8;
    assign o_receive_done_flag  = s.ri;
    assign o_transmit_done_flag = s.ti;
    assign o_transmit_busy      = busy_q;
    assign o_receive_busy       = rbusy_q;
endmodule

// file: fmsp_serial_port_props.sv
// Concurrent checks on the ports of the four mode serial port.
`timescale 1ns/100ps
module fmsp_serial_port_props (
    input wire logic       i_sys_clk,
    input wire logic       i_rst,
    input wire logic       i_mode_select_high,
    input wire logic       i_mode_select_low,
    input wire logic       i_shift_rate_or_multiproc_bit,
    input wire logic       i_receive_enable,
    input wire logic       i_serial_data_buffer_write,
    input wire logic       i_clear_receive_done,
    input wire logic       i_clear_transmit_done,
    input wire logic       o_data_pin,
    input wire logic       o_data_pin_oe_n,
    input wire logic       o_clock_pin,
    input wire logic [7:0] o_serial_data_buffer,
    input wire logic       o_receive_done_flag,
    input wire logic       o_transmit_done_flag,
    input wire logic       o_transmit_busy,
    input wire logic       o_receive_busy
);
    logic sync;
    logic fast;
    assign sync = !i_mode_select_high && !i_mode_select_low;
    assign fast = i_shift_rate_or_multiproc_bit;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence s_fast_low;
        !o_clock_pin [*2] ##1 o_clock_pin;
    endsequence
    sequence s_slow_low;
        !o_clock_pin [*6] ##1 o_clock_pin;
    endsequence
    a_fast_low_span: assert property (
        sync && fast && $fell(o_clock_pin) |-> s_fast_low)
        else $error("Fast shift clock low time is wrong.");
    a_fast_data_lead: assert property (
        sync && fast && !o_data_pin_oe_n && $changed(o_data_pin)
        |=> $fell(o_clock_pin)) else $error("Fast data lead is wrong.");
    a_slow_low_span: assert property (
        sync && !fast && $fell(o_clock_pin) |-> s_slow_low)
        else $error("Slow shift clock low time is wrong.");
    a_slow_data_lead: assert property (
        sync && !fast && !o_data_pin_oe_n && $changed(o_data_pin)
        |-> ##3 $fell(o_clock_pin)) else $error("Slow data lead wrong.");
    a_fast_frame_len: assert property (
        sync && fast && $fell(o_data_pin_oe_n) |-> ##32
        ($rose(o_data_pin_oe_n) && o_transmit_done_flag))
        else $error("Fast shift frame length is wrong.");
    a_drive_sync_only: assert property (
        !o_data_pin_oe_n |-> sync && !o_receive_busy)
        else $error("Data pin driven outside a shift transmit.");
    a_write_starts_tx: assert property (
        i_serial_data_buffer_write && !o_transmit_busy && !o_receive_busy
        |=> o_transmit_busy) else $error("Write did not start transmit.");
    a_sync_rx_start: assert property (
        sync && i_receive_enable && !o_receive_done_flag
        && !o_transmit_busy && !o_receive_busy && $stable(o_receive_busy)
        && !i_serial_data_buffer_write |=> o_receive_busy)
        else $error("Shift receive did not start.");
    a_rx_needs_enable: assert property (
        !i_receive_enable && !o_receive_busy |=> !o_receive_busy)
        else $error("Receive started while not allowed.");
    a_rx_flag_hold: assert property (
        o_receive_done_flag && !i_clear_receive_done
        |=> o_receive_done_flag && $stable(o_serial_data_buffer))
        else $error("Receive flag or buffer changed while held.");
    a_tx_flag_hold: assert property (
        o_transmit_done_flag && !i_clear_transmit_done
        |=> o_transmit_done_flag) else $error("Transmit flag dropped.");
endmodule
bind fmsp_serial_port fmsp_serial_port_props u_props (
    .i_sys_clk, .i_rst, .i_mode_select_high, .i_mode_select_low,
    .i_shift_rate_or_multiproc_bit, .i_receive_enable,
    .i_serial_data_buffer_write, .i_clear_receive_done,
    .i_clear_transmit_done, .o_data_pin, .o_data_pin_oe_n, .o_clock_pin,
    .o_serial_data_buffer, .o_receive_done_flag, .o_transmit_done_flag,
    .o_transmit_busy, .o_receive_busy);

// file: testbench.sv
// Self-checking testbench for the four mode serial port.
`timescale 1ns/100ps
module testbench;
    logic        i_sys_clk;
    logic        i_rst;
    logic [1:0]  mode;
    logic        sm2, en, dbl, ovf, t9, wr, clr_ri, clr_ti;
    logic [7:0]  wd, rbuf, d;
    logic        dat, oe_n, clk_pin, rb8, ri, ti, peer_line, pin_in;
    logic [2:0]  ovf_cnt;
    logic [10:0] got;
    logic [31:0] v;
    int          n_mismatch, check_count, seed, nb;
    logic [1:0]  cfg_mode [5] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
    logic        cfg_dbl [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    int          cfg_cpb [5] = '{32, 64, 128, 256, 128};
    fmsp_serial_port dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_mode_select_high(mode[1]), .i_mode_select_low(mode[0]),
        .i_shift_rate_or_multiproc_bit(sm2), .i_receive_enable(en),
        .i_double_rate(dbl), .i_timer_overflow(ovf),
        .i_transmit_ninth_bit(t9), .i_serial_data_buffer_write(wr),
        .i_serial_data_buffer_wdata(wd), .i_clear_receive_done(clr_ri),
        .i_clear_transmit_done(clr_ti), .i_data_pin(pin_in),
        .o_data_pin(dat), .o_data_pin_oe_n(oe_n), .o_clock_pin(clk_pin),
        .o_serial_data_buffer(rbuf), .o_ninth_receive_bit(rb8),
        .o_receive_done_flag(ri), .o_transmit_done_flag(ti),
        .o_transmit_busy(), .o_receive_busy());
    fmsp_peer peer (.i_sys_clk(i_sys_clk), .i_clk_pin(clk_pin),
        .i_dat_pin(dat), .i_oe_n(oe_n), .o_line(peer_line));
    assign pin_in = oe_n ? peer_line : dat;
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    // Rate timer overflow pulse once every 160 ns.
    always @(posedge i_sys_clk) begin
        ovf_cnt <= ovf_cnt + 3'h1;
        ovf <= (ovf_cnt == 3'h7);
    end
    task automatic chk_val(input logic [10:0] g, input logic [10:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_flag(input logic g, input logic e);
        chk_val({10'h000, g}, {10'h000, e});
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_flag(input logic rx);
        int t;
        t = 0;
        while ((rx ? ri : ti) !== 1'b1) begin
            @(posedge i_sys_clk);
            #1;
            t++;
            if (t > 9000) begin
                n_mismatch++;
                final_report();
            end
        end
    endtask
    task automatic write_buf(input logic [7:0] b, input logic n9);
        @(posedge i_sys_clk);
        wr <= 1'b1;
        wd <= b;
        t9 <= n9;
        @(posedge i_sys_clk);
        wr <= 1'b0;
    endtask
    task automatic clear_flags;
        @(posedge i_sys_clk);
        {clr_ri, clr_ti} <= 2'h3;
        @(posedge i_sys_clk);
        {clr_ri, clr_ti} <= 2'h0;
    endtask
    function automatic logic [10:0] frame_of(input logic [1:0] m,
        input logic [7:0] b, input logic n9);
        return (m == 2'h1) ? {2'b11, b, 1'b0} : {1'b1, n9, b, 1'b0};
    endfunction
    initial begin
        seed = 32'h86732B41;
        {mode, sm2, en, dbl, ovf, t9, wr, wd, clr_ri, clr_ti} = '0;
        {n_mismatch, check_count, ovf_cnt} = '0;
        i_rst = 1'b1;
        repeat (12) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        #1;
        chk_val({dat, oe_n, clk_pin, rbuf}, 11'h700);
        chk_val({9'h000, ri, ti}, 11'h000);
        // A second write during a shift frame is dropped.
        for (int k = 0; k < 6; k++) begin
            d = 8'($random(seed));
            sm2 <= k[0];
            write_buf(d, 1'b0);
            write_buf(~d, 1'b0);
            wait_flag(1'b0);
            chk_val({3'h0, peer.sync_rx}, {3'h0, d});
            clear_flags();
        end
        for (int k = 0; k < 2; k++) begin
            d = 8'($random(seed));
            @(posedge i_sys_clk);
            sm2 <= k[0];
            peer.arm_sync(d);
            en <= 1'b1;
            wait_flag(1'b1);
            en <= 1'b0;
            peer.armed <= 1'b0;
            chk_val({3'h0, rbuf}, {3'h0, d});
            clear_flags();
        end
        for (int k = 0; k < 5; k++) begin
            v = $random(seed);
            nb = (cfg_mode[k] == 2'h1) ? 10 : 11;
            @(posedge i_sys_clk);
            {mode, sm2, dbl} <= {cfg_mode[k], 1'b0, cfg_dbl[k]};
            en <= 1'b1;
            fork
                write_buf(v[7:0], v[16]);
                peer.get_frame(nb, cfg_cpb[k], got);
                peer.send_frame(frame_of(cfg_mode[k], v[15:8], v[17]),
                                nb, cfg_cpb[k]);
            join
            wait_flag(1'b1);
            wait_flag(1'b0);
            chk_val(got, frame_of(cfg_mode[k], v[7:0], v[16]));
            chk_val({rb8, 2'h0, rbuf}, {(nb == 10) | v[17], 2'h0, v[15:8]});
            clear_flags();
        end
        // Filtered stop low, filtered ninth low, then receive not allowed.
        for (int k = 0; k < 3; k++) begin
            @(posedge i_sys_clk);
            {mode, sm2, en} <= {(k == 0) ? 2'h1 : 2'h2, k < 2, k < 2};
            peer.send_frame(11'h54A, (k == 0) ? 10 : 11, (k == 0) ? 128 : 32);
            repeat (300) @(posedge i_sys_clk);
            #1;
            chk_flag(ri, 1'b0);
            chk_val({3'h0, rbuf}, {3'h0, v[15:8]});
        end
        final_report();
    end
endmodule
